/* File: shared/flash_seq_pkg.sv */
// Purpose: shared constants for the flash program/erase control block
// Assumes: AXI4-Lite slave with 32-bit data, word-aligned registers
// Notes:   control bit positions are shared by both region control registers
package flash_seq_pkg;

	localparam int          ADDR_W            = 8;
	localparam int          DATA_W            = 32;
	localparam int          REGION_W          = 8;
	localparam int          STS_W             = 4;

	// Register byte offsets
	localparam logic [7:0]  OFS_LOWER_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_UPPER_CTRL    = 8'h04;
	localparam logic [7:0]  OFS_EBMASK_FIRST  = 8'h08;
	localparam logic [7:0]  OFS_EBMASK_SECOND = 8'h0C;
	localparam logic [7:0]  OFS_RAM_EMU       = 8'h10;
	localparam logic [7:0]  OFS_IRQ_STATUS    = 8'h14;
	localparam logic [7:0]  OFS_IRQ_MASK      = 8'h18;
	localparam logic [7:0]  OFS_OP_STATE      = 8'h1C;
	localparam logic [7:0]  OFS_WAIT_CFG      = 8'h20;
	localparam logic [7:0]  OFS_PROG_COUNT    = 8'h24;

	// Control register fields (both regions; BIT_FLASH_ERROR reads in upper only, BIT_RAM_EMU_SEL is in RAM emulation)
	localparam int          BIT_PROG_GO       = 0;
	localparam int          BIT_ERASE_GO      = 1;
	localparam int          BIT_PROG_VERIFY   = 2;
	localparam int          BIT_ERASE_VERIFY  = 3;
	localparam int          BIT_PROG_SETUP    = 4;
	localparam int          BIT_ERASE_SETUP   = 5;
	localparam int          BIT_SW_WE         = 6;
	localparam int          BIT_FLASH_ERROR   = 7;
	localparam int          BIT_RAM_EMU_SEL   = 3;

	// Interrupt status bits
	localparam int          IRQ_OP_DONE       = 0;
	localparam int          IRQ_ERROR         = 1;
	localparam int          IRQ_PROTECT       = 2;
	localparam int          IRQ_COUNT_OVER    = 3;

	localparam logic [7:0]  CTRL_RESET        = 8'h00;
	localparam logic [7:0]  EBMASK_RESET      = 8'h00;
	localparam logic [15:0] WAIT_RESET        = 16'h0010;
	localparam logic [7:0]  PROG_MAX_RESET    = 8'h0A;

	// Flash address regions
	localparam logic [23:0] LOWER_BASE        = 24'h000000;
	localparam logic [23:0] LOWER_LAST        = 24'h03FFFF;
	localparam logic [23:0] UPPER_BASE        = 24'h040000;
	localparam logic [23:0] UPPER_LAST        = 24'h07FFFF;

	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;

	typedef enum logic [2:0]
	{
		ST_IDLE   = 3'b000,
		ST_SETUP  = 3'b001,
		ST_ACTIVE = 3'b011,
		ST_VERIFY = 3'b010,
		ST_ERROR  = 3'b110
	} op_state_e;

endpackage : flash_seq_pkg

/* File: verilog/flash_wait_timer.sv */
// Purpose: reloadable down-counter for program/erase wait times
// Assumes: load takes priority over counting
// Notes:   done is a registered level while the count is zero
`timescale 1ns/100ps
module flash_wait_timer #(
	parameter int W = 16
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              done
);
	logic [W-1:0] count_q;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			count_q <= '0;
		else if (load)
			count_q <= value;
		else if (count_q != '0)
			count_q <= count_q - W'(1);
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			done <= 1'b1;
		else
			done <= !load && (count_q <= W'(1));
	end
endmodule : flash_wait_timer

/* File: verilog/flash_program_erase_protect.sv */
// Purpose: program/erase control and protection for two flash regions
// Assumes: AXI4-Lite register access, single clock mclk, sync reset
// Notes:   one write and one read handled at a time
`timescale 1ns/100ps
module flash_program_erase_protect #(
	parameter int                 WAIT_W     = 16,
	parameter int                 BLOCKS     = 16,
	parameter logic [15:0]        WAIT_INIT  = flash_seq_pkg::WAIT_RESET,
	parameter logic [7:0]         PROG_MAX   = flash_seq_pkg::PROG_MAX_RESET
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	input  wire logic             hardware_write_enable_input,
	input  wire logic             cpu_runaway,
	input  wire logic [3:0]       erase_block_sel,
	output logic                  flash_prog_lower,
	output logic                  flash_prog_upper,
	output logic                  flash_erase_lower,
	output logic                  flash_erase_upper,
	output logic                  flash_verify,
	output logic                  flash_read_block,
	output logic                  irq
);
	logic [7:0]        lower_region_flash_control_q;
	logic [7:0]        upper_region_flash_control_q;
	logic [7:0]        erase_block_mask_first_q;
	logic [7:0]        erase_block_mask_second_q;
	logic [7:0]        ram_emulation_control_q;
	logic [3:0]        sts_q;
	logic [3:0]        mask_q;
	logic [15:0]       wait_cfg_q;
	logic [7:0]        prog_max_q;
	logic [7:0]        prog_count_q;
	logic              error_q;
	flash_seq_pkg::op_state_e state_q;

	logic              aw_held_q, w_held_q;
	logic [7:0]        awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              wr_fire;
	logic [7:0]        ctrl_wr_lo, ctrl_wr_hi;
	logic              any_go, any_setup, violation, op_done;
	logic              prog_go_lo, prog_go_hi, erase_go_lo, erase_go_hi;
	logic              lower_ok, upper_ok, erase_ok, timer_done, timer_load;
	logic [7:0]        rd_ctrl;
	logic [3:0]        sts_set;

	// Write data with byte lane 0 applied over the old value
	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		merge_byte = strb[0] ? d[7:0] : old;
	endfunction : merge_byte

	function automatic logic wr_hit(input logic fire, input logic [7:0] a, input logic [7:0] ofs);
		wr_hit = fire && (a == ofs);
	endfunction : wr_hit

	// AXI write channel: address and data taken in either order
	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= '0;
			wstrb_q       <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= flash_seq_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q     <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q     <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q[1:0] == 2'h0 && awaddr_q <= flash_seq_pkg::OFS_PROG_COUNT)
					? flash_seq_pkg::RESP_OKAY : flash_seq_pkg::RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Protection terms
	assign lower_ok = hardware_write_enable_input
		&& lower_region_flash_control_q[flash_seq_pkg::BIT_SW_WE]
		&& !ram_emulation_control_q[flash_seq_pkg::BIT_RAM_EMU_SEL];
	assign upper_ok = hardware_write_enable_input
		&& upper_region_flash_control_q[flash_seq_pkg::BIT_SW_WE]
		&& !ram_emulation_control_q[flash_seq_pkg::BIT_RAM_EMU_SEL];
	// Reduce only after masking, so just the addressed block's bit counts
	assign erase_ok = |({erase_block_mask_second_q, erase_block_mask_first_q}
		& (BLOCKS'(1) << erase_block_sel));

	assign ctrl_wr_lo = merge_byte(lower_region_flash_control_q, wdata_q, wstrb_q);
	assign ctrl_wr_hi = merge_byte(upper_region_flash_control_q, wdata_q, wstrb_q);

	// Go bits refused in error protection, verify bits still pass
	assign prog_go_lo  = lower_region_flash_control_q[flash_seq_pkg::BIT_PROG_GO] && lower_ok
		&& lower_region_flash_control_q[flash_seq_pkg::BIT_PROG_SETUP] && !error_q;
	assign erase_go_lo = lower_region_flash_control_q[flash_seq_pkg::BIT_ERASE_GO] && lower_ok
		&& lower_region_flash_control_q[flash_seq_pkg::BIT_ERASE_SETUP] && erase_ok && !error_q;
	assign prog_go_hi  = upper_region_flash_control_q[flash_seq_pkg::BIT_PROG_GO] && upper_ok
		&& upper_region_flash_control_q[flash_seq_pkg::BIT_PROG_SETUP] && !error_q;
	assign erase_go_hi = upper_region_flash_control_q[flash_seq_pkg::BIT_ERASE_GO] && upper_ok
		&& upper_region_flash_control_q[flash_seq_pkg::BIT_ERASE_SETUP] && erase_ok && !error_q;
	assign any_go    = prog_go_lo || erase_go_lo || prog_go_hi || erase_go_hi;
	assign any_setup = lower_region_flash_control_q[flash_seq_pkg::BIT_PROG_SETUP]
		|| lower_region_flash_control_q[flash_seq_pkg::BIT_ERASE_SETUP]
		|| upper_region_flash_control_q[flash_seq_pkg::BIT_PROG_SETUP]
		|| upper_region_flash_control_q[flash_seq_pkg::BIT_ERASE_SETUP];

	// Algorithm violation: runaway, setup dropped while active, or program and erase go both set
	assign violation = cpu_runaway
		|| (state_q == flash_seq_pkg::ST_ACTIVE && !any_setup)
		|| ((lower_region_flash_control_q[flash_seq_pkg::BIT_PROG_GO]
			|| upper_region_flash_control_q[flash_seq_pkg::BIT_PROG_GO])
			&& (lower_region_flash_control_q[flash_seq_pkg::BIT_ERASE_GO]
			|| upper_region_flash_control_q[flash_seq_pkg::BIT_ERASE_GO]));

	assign op_done    = state_q == flash_seq_pkg::ST_ACTIVE && !any_go && timer_done;
	assign timer_load = state_q == flash_seq_pkg::ST_IDLE && any_setup;

	flash_wait_timer #(.W(WAIT_W)) u_timer (
		.mclk  (mclk),
		.rst_n (rst_n),
		.load  (timer_load),
		.value (WAIT_W'(wait_cfg_q)),
		.done  (timer_done)
	);

	// Registers keep their contents when error protection is entered
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			lower_region_flash_control_q <= flash_seq_pkg::CTRL_RESET;
			upper_region_flash_control_q <= flash_seq_pkg::CTRL_RESET;
			erase_block_mask_first_q     <= flash_seq_pkg::EBMASK_RESET;
			erase_block_mask_second_q    <= flash_seq_pkg::EBMASK_RESET;
			ram_emulation_control_q      <= flash_seq_pkg::CTRL_RESET;
			mask_q                       <= '0;
			wait_cfg_q                   <= WAIT_INIT;
			prog_max_q                   <= PROG_MAX;
		end
		else
		begin
			if (wr_hit(wr_fire, awaddr_q, flash_seq_pkg::OFS_LOWER_CTRL))
				lower_region_flash_control_q <= {1'b0, ctrl_wr_lo[6:0]};
			if (wr_hit(wr_fire, awaddr_q, flash_seq_pkg::OFS_UPPER_CTRL))
				upper_region_flash_control_q <= {1'b0, ctrl_wr_hi[6:0]};
			if (wr_hit(wr_fire, awaddr_q, flash_seq_pkg::OFS_EBMASK_FIRST))
				erase_block_mask_first_q <= merge_byte(erase_block_mask_first_q, wdata_q, wstrb_q);
			if (wr_hit(wr_fire, awaddr_q, flash_seq_pkg::OFS_EBMASK_SECOND))
				erase_block_mask_second_q <= merge_byte(erase_block_mask_second_q, wdata_q, wstrb_q);
			if (wr_hit(wr_fire, awaddr_q, flash_seq_pkg::OFS_RAM_EMU))
				ram_emulation_control_q <= merge_byte(ram_emulation_control_q, wdata_q, wstrb_q);
			if (wr_hit(wr_fire, awaddr_q, flash_seq_pkg::OFS_IRQ_MASK))
				mask_q <= wdata_q[3:0];
			if (wr_hit(wr_fire, awaddr_q, flash_seq_pkg::OFS_WAIT_CFG))
				wait_cfg_q <= wdata_q[15:0];
			if (wr_hit(wr_fire, awaddr_q, flash_seq_pkg::OFS_PROG_COUNT))
				prog_max_q <= wdata_q[7:0];
		end
	end

	// Sequence state
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			state_q <= flash_seq_pkg::ST_IDLE;
		else if (violation && state_q != flash_seq_pkg::ST_ERROR)
			state_q <= flash_seq_pkg::ST_ERROR;
		else
			case (state_q)
				flash_seq_pkg::ST_IDLE:
					if (any_setup)
						state_q <= flash_seq_pkg::ST_SETUP;
				flash_seq_pkg::ST_SETUP:
					if (any_go && timer_done)
						state_q <= flash_seq_pkg::ST_ACTIVE;
					else if (!any_setup)
						state_q <= flash_seq_pkg::ST_IDLE;
				flash_seq_pkg::ST_ACTIVE:
					if (op_done)
						state_q <= flash_seq_pkg::ST_VERIFY;
				flash_seq_pkg::ST_VERIFY:
					if (!any_setup)
						state_q <= flash_seq_pkg::ST_IDLE;
					else if (any_go)
						state_q <= flash_seq_pkg::ST_ACTIVE;
				flash_seq_pkg::ST_ERROR:
					state_q <= flash_seq_pkg::ST_ERROR;
				default:
					state_q <= flash_seq_pkg::ST_IDLE;
			endcase
	end

	// Error flag and attempt counter
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			error_q      <= 1'b0;
			prog_count_q <= '0;
		end
		else
		begin
			if (violation)
				error_q <= 1'b1;
			if (state_q == flash_seq_pkg::ST_IDLE)
				prog_count_q <= '0;
			else if (state_q == flash_seq_pkg::ST_SETUP && any_go && timer_done)
				prog_count_q <= prog_count_q + 8'h01;
		end
	end

	// Sticky status, set wins over write-one-clear
	assign sts_set = {prog_count_q > prog_max_q,
		(|{lower_region_flash_control_q[1:0], upper_region_flash_control_q[1:0]})
			&& !any_go && !error_q,
		violation, op_done};

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			sts_q <= '0;
		else if (wr_hit(wr_fire, awaddr_q, flash_seq_pkg::OFS_IRQ_STATUS))
			sts_q <= (sts_q & ~wdata_q[3:0]) | sts_set;
		else
			sts_q <= sts_q | sts_set;
	end

	// Flash array strobes, all but flash_verify dropped at once on error
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			flash_prog_lower  <= 1'b0;
			flash_prog_upper  <= 1'b0;
			flash_erase_lower <= 1'b0;
			flash_erase_upper <= 1'b0;
			flash_verify      <= 1'b0;
			flash_read_block  <= 1'b0;
			irq               <= 1'b0;
		end
		else
		begin
			flash_prog_lower  <= prog_go_lo && !violation;
			flash_prog_upper  <= prog_go_hi && !violation;
			flash_erase_lower <= erase_go_lo && !violation;
			flash_erase_upper <= erase_go_hi && !violation;
			flash_verify      <= |{lower_region_flash_control_q[3:2],
				upper_region_flash_control_q[3:2]};
			flash_read_block  <= any_go && !violation;
			irq               <= |(sts_q & mask_q);
		end
	end

	assign rd_ctrl = {error_q, upper_region_flash_control_q[6:0]};

	// AXI read channel
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= flash_seq_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= flash_seq_pkg::RESP_OKAY;
				case (s_axi_araddr)
					flash_seq_pkg::OFS_LOWER_CTRL:    s_axi_rdata <= {24'h0, lower_region_flash_control_q};
					flash_seq_pkg::OFS_UPPER_CTRL:    s_axi_rdata <= {24'h0, rd_ctrl};
					flash_seq_pkg::OFS_EBMASK_FIRST:  s_axi_rdata <= {24'h0, erase_block_mask_first_q};
					flash_seq_pkg::OFS_EBMASK_SECOND: s_axi_rdata <= {24'h0, erase_block_mask_second_q};
					flash_seq_pkg::OFS_RAM_EMU:       s_axi_rdata <= {24'h0, ram_emulation_control_q};
					flash_seq_pkg::OFS_IRQ_STATUS:    s_axi_rdata <= {28'h0, sts_q};
					flash_seq_pkg::OFS_IRQ_MASK:      s_axi_rdata <= {28'h0, mask_q};
					flash_seq_pkg::OFS_OP_STATE:      s_axi_rdata <= {29'h0, state_q};
					flash_seq_pkg::OFS_WAIT_CFG:      s_axi_rdata <= {16'h0, wait_cfg_q};
					flash_seq_pkg::OFS_PROG_COUNT:    s_axi_rdata <= {16'h0, prog_count_q, prog_max_q};
					default:
					begin
						s_axi_rdata <= '0;
						s_axi_rresp <= flash_seq_pkg::RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule : flash_program_erase_protect

/* File: tb/flash_array_model.sv */
// Purpose: behavioural flash array on the far side of the array strobes
// Assumes: strobes are registered levels from the control block
// Notes:   counts 128-byte program passes and flags dual-region programming
`timescale 1ns/100ps
module flash_array_model (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       prog_lo,
	input  wire logic       prog_up,
	input  wire logic [3:0] blk,
	output logic      [3:0] erase_block_sel,
	output logic      [7:0] prog_cnt,
	output logic            overlap
);
	logic	prog_q;

	// Block index only means something while an erase is selected
	assign erase_block_sel = blk;
	always_ff @(posedge mclk)
		if (!rst_n)
		begin
			prog_cnt <= 8'h00;
			prog_q <= 1'h0;
			overlap <= 1'h0;
		end
		else
		begin
			prog_q <= prog_lo | prog_up;
			// One pass writes one 128-byte row; each row once only
			if ((prog_lo | prog_up) && !prog_q)
				prog_cnt <= prog_cnt + 8'h01;
			if (prog_lo && prog_up)
				overlap <= 1'h1;
		end
endmodule : flash_array_model

/* File: tb/flash_seq_props.sv */
// Purpose: port-level checks of the flash program/erase control block
// Assumes: single clock, synchronous active-low reset
// Notes:   error state is tracked locally from the runaway input
`timescale 1ns/100ps
module flash_seq_props (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        hardware_write_enable_input,
	input wire logic        cpu_runaway,
	input wire logic        flash_prog_lower,
	input wire logic        flash_prog_upper,
	input wire logic        flash_erase_lower,
	input wire logic        flash_erase_upper,
	input wire logic        flash_verify,
	input wire logic        flash_read_block,
	input wire logic        irq
);
	logic	any;
	logic	err_q;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	assign any = flash_prog_lower | flash_prog_upper | flash_erase_lower | flash_erase_upper;
	always_ff @(posedge mclk)
		if (!rst_n)
			err_q <= 1'h0;
		else if (cpu_runaway)
			err_q <= 1'h1;

	property p_no_hw;
		!hardware_write_enable_input [*3] |-> !any;
	endproperty
	a_no_hw: assert property (p_no_hw) else $error("strobe without hw enable");
	property p_read_block;
		any |-> flash_read_block;
	endproperty
	a_read_block: assert property (p_read_block) else $error("reads open in op");
	property p_abort;
		cpu_runaway |=> !any;
	endproperty
	a_abort: assert property (p_abort) else $error("op not aborted");
	property p_sticky;
		err_q |-> !any;
	endproperty
	a_sticky: assert property (p_sticky) else $error("op restarted in error");
	property p_reset_quiet;
		disable iff (1'h0) !rst_n |=> !(any | irq | s_axi_bvalid | s_axi_rvalid);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
	property p_b_order;
		s_axi_bvalid |-> !s_axi_awready;
	endproperty
	a_b_order: assert property (p_b_order) else $error("awready during resp");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read resp changed");
	property p_ar_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_ar_answer: assert property (p_ar_answer) else $error("late read resp");
	c_prog: cover property (flash_prog_lower);
	c_erase: cover property (flash_erase_upper);
	c_verify: cover property (flash_verify && err_q);
	c_irq: cover property (irq);
endmodule : flash_seq_props

bind flash_program_erase_protect flash_seq_props u_props (.mclk, .rst_n, .s_axi_awready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .hardware_write_enable_input, .cpu_runaway,
	.flash_prog_lower, .flash_prog_upper, .flash_erase_lower, .flash_erase_upper,
	.flash_verify, .flash_read_block, .irq);

/* File: tb/test_flash_program_erase_protect.sv */
// Purpose: self-checking bench for the flash program/erase control block
// Assumes: AXI4-Lite master tasks, strobes settle within four cycles
// Notes:   error protection is sticky, so that scenario runs last
`timescale 1ns/100ps
module test_flash_program_erase_protect;
	logic        mclk, rst_n, hardware_write_enable_input, cpu_runaway;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, prog_cnt;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, erase_block_sel, blk;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        flash_prog_lower, flash_prog_upper, flash_erase_lower, flash_erase_upper;
	logic        flash_verify, flash_read_block, irq, overlap;
	int          err_total, cmp_count;
	localparam logic [31:0] ONE = 32'h1;
	localparam logic [31:0] PG  = ONE << flash_seq_pkg::BIT_PROG_GO;
	localparam logic [31:0] EG  = ONE << flash_seq_pkg::BIT_ERASE_GO;
	localparam logic [31:0] PV  = ONE << flash_seq_pkg::BIT_PROG_VERIFY;
	localparam logic [31:0] EV  = ONE << flash_seq_pkg::BIT_ERASE_VERIFY;
	localparam logic [31:0] SWE = ONE << flash_seq_pkg::BIT_SW_WE;
	localparam logic [31:0] PSW = SWE | (ONE << flash_seq_pkg::BIT_PROG_SETUP);
	localparam logic [31:0] ESW = SWE | (ONE << flash_seq_pkg::BIT_ERASE_SETUP);
	localparam logic [7:0]  LO  = flash_seq_pkg::OFS_LOWER_CTRL;
	localparam logic [7:0]  UP  = flash_seq_pkg::OFS_UPPER_CTRL;
	localparam logic [7:0]  STS = flash_seq_pkg::OFS_IRQ_STATUS;

	flash_program_erase_protect #(.WAIT_INIT(16'h0002)) dut (.mclk, .rst_n, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .hardware_write_enable_input, .cpu_runaway, .erase_block_sel,
		.flash_prog_lower, .flash_prog_upper, .flash_erase_lower, .flash_erase_upper,
		.flash_verify, .flash_read_block, .irq);
	flash_array_model u_array (.mclk, .rst_n, .prog_lo(flash_prog_lower),
		.prog_up(flash_prog_upper), .blk, .erase_block_sel, .prog_cnt, .overlap);

	always #12.5 mclk = ~mclk;

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("Error at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit aw, w;
		aw = 0;
		w = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (!(aw && w))
		begin
			@(posedge mclk);
			if (!aw && s_axi_awready)
			begin
				aw = 1;
				s_axi_awvalid <= 1'h0;
			end
			if (!w && s_axi_wready)
			begin
				w = 1;
				s_axi_wvalid <= 1'h0;
			end
		end
		while (!s_axi_bvalid) @(posedge mclk);
		s_axi_bready <= 1'h1;
		@(posedge mclk);
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, flash_seq_pkg::RESP_OKAY);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		while (!s_axi_rvalid) @(posedge mclk);
		s_axi_rready <= 1'h1;
		@(posedge mclk);
		s_axi_rready <= 1'h0;
		chk(s_axi_rresp, r);
		chk(s_axi_rdata, e);
	endtask : rd

	task automatic strobes(input logic [3:0] e);
		repeat (4) @(posedge mclk);
		chk({flash_prog_lower, flash_prog_upper, flash_erase_lower, flash_erase_upper}, e);
	endtask : strobes

	task automatic do_reset();
		@(posedge mclk);
		rst_n <= 1'h0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'h1;
	endtask : do_reset

	task automatic t_reset_values();
		for (int i = 0; i < 5; i++)
			rd(8'(4 * i), 32'h0, flash_seq_pkg::RESP_OKAY);
		rd(8'h3C, 32'h0, flash_seq_pkg::RESP_SLVERR);
		chk(irq, 1'h0);
	endtask : t_reset_values

	task automatic t_program();
		for (int r = 0; r < 2; r++)
		begin
			wr(r ? UP : LO, PSW);
			wr(r ? UP : LO, PSW | PG);
			strobes(r ? 4'h4 : 4'h8);
			chk(flash_read_block, 1'h1);
			wr(r ? UP : LO, PSW);
			strobes(4'h0);
			wr(r ? UP : LO, 32'h0);
		end
		chk(prog_cnt, 8'h02);
		rd(STS, ONE << flash_seq_pkg::IRQ_OP_DONE, flash_seq_pkg::RESP_OKAY);
	endtask : t_program

	task automatic t_protect();
		for (int k = 0; k < 4; k++)
		begin
			wr(STS, 32'hF);
			hardware_write_enable_input <= (k != 2);
			if (k == 3)
				wr(flash_seq_pkg::OFS_RAM_EMU, ONE << flash_seq_pkg::BIT_RAM_EMU_SEL);
			wr(k == 1 ? UP : LO, (k < 2) ? (PSW & ~SWE) : PSW);
			wr(k == 1 ? UP : LO, ((k < 2) ? (PSW & ~SWE) : PSW) | PG);
			strobes(4'h0);
			rd(STS, ONE << flash_seq_pkg::IRQ_PROTECT, flash_seq_pkg::RESP_OKAY);
			wr(k == 1 ? UP : LO, 32'h0);
			wr(flash_seq_pkg::OFS_RAM_EMU, 32'h0);
		end
		hardware_write_enable_input <= 1'h1;
	endtask : t_protect

	task automatic t_erase();
		blk <= 4'h5;
		wr(LO, ESW);
		wr(LO, ESW | EG);
		strobes(4'h0);
		wr(LO, ESW);
		wr(flash_seq_pkg::OFS_EBMASK_FIRST, 32'h20);
		wr(LO, ESW | EG);
		strobes(4'h2);
		// Go must drop before setup, or the sequencer flags an algorithm error
		wr(LO, ESW);
		wr(LO, 32'h0);
		blk <= 4'h9;
		wr(flash_seq_pkg::OFS_EBMASK_SECOND, 32'h02);
		wr(UP, ESW);
		wr(UP, ESW | EG);
		strobes(4'h1);
		wr(UP, ESW);
		wr(UP, 32'h0);
	endtask : t_erase

	task automatic t_verify();
		for (int v = 0; v < 2; v++)
		begin
			wr(v ? UP : LO, SWE | (v ? EV : PV));
			strobes(4'h0);
			chk(flash_verify, 1'h1);
			wr(v ? UP : LO, 32'h0);
		end
	endtask : t_verify

	task automatic t_error();
		wr(flash_seq_pkg::OFS_IRQ_MASK, ONE << flash_seq_pkg::IRQ_ERROR);
		wr(STS, 32'hF);
		wr(LO, PSW);
		wr(LO, PSW | PG);
		strobes(4'h8);
		// Abort in mid-program by pulsing cpu_runaway for one cycle
		cpu_runaway <= 1'h1;
		@(posedge mclk);
		cpu_runaway <= 1'h0;
		strobes(4'h0);
		chk(irq, 1'h1);
		rd(UP, ONE << flash_seq_pkg::BIT_FLASH_ERROR, flash_seq_pkg::RESP_OKAY);
		rd(LO, PSW | PG, flash_seq_pkg::RESP_OKAY);
		rd(flash_seq_pkg::OFS_EBMASK_FIRST, 32'h20, flash_seq_pkg::RESP_OKAY);
		wr(LO, PSW);
		wr(LO, PSW | PG);
		strobes(4'h0);
		wr(UP, SWE | EV);
		strobes(4'h0);
		chk(flash_verify, 1'h1);
		wr(STS, ONE << flash_seq_pkg::IRQ_ERROR);
		repeat (2) @(posedge mclk);
		chk(irq, 1'h0);
		chk(overlap, 1'h0);
	endtask : t_error

	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	initial
	begin
		repeat (40000) @(posedge mclk);
		err_total++;
		finish_test();
	end

	initial
	begin
		{mclk, rst_n, cpu_runaway, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, blk} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		hardware_write_enable_input = 1'h1;
		do_reset();
		t_reset_values();
		t_program();
		t_protect();
		t_erase();
		t_verify();
		t_error();
		do_reset();
		rd(UP, 32'h0, flash_seq_pkg::RESP_OKAY);
		finish_test();
	end
endmodule : test_flash_program_erase_protect
